// [xcbt_regs.svh]
`ifndef XCBT_REGS_SVH
`define XCBT_REGS_SVH
`define XCBT_CHAIN_WIDTH 88
`define XCBT_MODE_RESET 1'h0
`define XCBT_OUT_RESET 1'h0
`define XCBT_PIN_RESET 1'h0
`define XCBT_RESET_PIN_IDLE 1'h1
`endif

// [xcbt_pkg.sv]
package xcbt_pkg;
	typedef enum logic {XCBT_NORMAL, XCBT_CHAIN} xcbt_mode_t;
	typedef struct packed {
		logic system_reset_pin;
		logic host_frame_pin;
		logic host_bus_bit0_pin;
	} xcbt_strap_t;
endpackage

// [xcbt_top.sv]
`timescale 1ns/100ps
`default_nettype none
`include "xcbt_regs.svh"
module xcbt_top import xcbt_pkg::*; #(
	parameter int CHAIN_WIDTH = `XCBT_CHAIN_WIDTH
) (
	// Clock and power-on reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Strap and reset pins
	input wire xcbt_strap_t strap_pins,
	// Every other chain input pin
	input wire logic [CHAIN_WIDTH-1:0] chain_pins,
	// Normal-function output from the core
	input wire logic chain_output_func,
	input wire logic chain_output_func_oe,
	// Chain output pin
	output logic chain_output_pin_o,
	output logic chain_output_pin_oe,
	// Other pin drivers must be released while high
	output logic pins_disconnect
);

	localparam int NIN = CHAIN_WIDTH + 2;
	// Positions in the raw vector; frame and bit 0 sit just below the reset pin
	localparam int RST_BIT = NIN;
	localparam int FRAME_BIT = NIN - 1;
	localparam int BIT0_BIT = NIN - 2;
	// The reset pin rests high in normal use, so the filter starts there:
	// a power-on reset with the pin already high must not look like an edge.
	localparam logic [NIN:0] IDLE = {`XCBT_RESET_PIN_IDLE, {NIN{`XCBT_PIN_RESET}}};

	// ==========================================================
	// Helper functions
	// A level is taken only once stages two and three agree.
	function automatic logic [NIN:0] xcbt_filter(
		input logic [NIN:0] cur,
		input logic [NIN:0] a,
		input logic [NIN:0] b
	);
		logic [NIN:0] r;
		r = cur;
		for (int i = 0; i <= NIN; i++) begin
			if (a[i] == b[i]) begin
				r[i] = b[i];
			end
		end
		return r;
	endfunction

	// Even count of inputs: all low and all high both give low.
	function automatic logic xcbt_parity(input logic [NIN-1:0] v);
		return ^v;
	endfunction

	function automatic logic xcbt_rise(input logic now_v, input logic was_v);
		return now_v && !was_v;
	endfunction

	// ==========================================================
	// Input synchroniser, stage one
	// Frame and bit 0 ride in the chain vector.
	logic [NIN:0] raw;
	logic [NIN:0] s1_q, s1_d;

	always_comb begin
		raw = {strap_pins.system_reset_pin, strap_pins.host_frame_pin,
			strap_pins.host_bus_bit0_pin, chain_pins};
		s1_d = raw;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s1_q <= IDLE;
		end else begin
			s1_q <= s1_d;
		end
	end

	// ==========================================================
	// Input synchroniser, stage two
	logic [NIN:0] s2_q, s2_d;

	always_comb begin
		s2_d = s1_q;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s2_q <= IDLE;
		end else begin
			s2_q <= s2_d;
		end
	end

	// ==========================================================
	// Input synchroniser, stage three
	logic [NIN:0] s3_q, s3_d;

	always_comb begin
		s3_d = s2_q;
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			s3_q <= IDLE;
		end else begin
			s3_q <= s3_d;
		end
	end

	// ==========================================================
	// Filtered levels
	// Pulses shorter than two cycles never reach the chain.
	logic [NIN:0] lvl_q, lvl_d;

	always_comb begin
		lvl_d = xcbt_filter(lvl_q, s2_q, s3_q);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			lvl_q <= IDLE;
		end else begin
			lvl_q <= lvl_d;
		end
	end

	// ==========================================================
	// Mode flag
	xcbt_mode_t mode_q, mode_d;
	logic rst_rise;

	always_comb begin
		rst_rise = xcbt_rise(lvl_d[RST_BIT], lvl_q[RST_BIT]);
		mode_d = mode_q;
		if (rst_rise) begin
			unique case (mode_q)
				XCBT_NORMAL: begin
					if (!lvl_d[FRAME_BIT] && !lvl_d[BIT0_BIT]) begin
						mode_d = XCBT_CHAIN;
					end
				end
				XCBT_CHAIN: begin
					if (lvl_d[FRAME_BIT] || lvl_d[BIT0_BIT]) begin
						mode_d = XCBT_NORMAL;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mode_q <= XCBT_NORMAL;
		end else begin
			mode_q <= mode_d;
		end
	end

	// ==========================================================
	// Pin disconnect
	logic disc_q, disc_d;

	always_comb begin
		disc_d = (mode_d == XCBT_CHAIN);
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			disc_q <= `XCBT_MODE_RESET;
		end else begin
			disc_q <= disc_d;
		end
	end

	// ==========================================================
	// Chain output
	logic out_q, out_d, oe_q, oe_d;

	always_comb begin
		if (mode_d == XCBT_CHAIN) begin
			out_d = xcbt_parity(lvl_d[NIN-1:0]);
			oe_d = 1'h1;
		end else begin
			// Normal function returns at once, so the pin stops following the chain.
			out_d = chain_output_func;
			oe_d = chain_output_func_oe;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			out_q <= `XCBT_OUT_RESET;
			oe_q <= `XCBT_MODE_RESET;
		end else begin
			out_q <= out_d;
			oe_q <= oe_d;
		end
	end

	// ==========================================================
	// Output ports
	always_comb begin
		chain_output_pin_o = out_q;
		chain_output_pin_oe = oe_q;
		pins_disconnect = disc_q;
	end

endmodule
`default_nettype wire

// [xcbt_top_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module xcbt_chk import xcbt_pkg::*; #(parameter int CHAIN_WIDTH = 88) (
	// Watched ports
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire xcbt_strap_t strap_pins,
	input wire logic [CHAIN_WIDTH-1:0] chain_pins,
	input wire logic chain_output_func,
	input wire logic chain_output_func_oe,
	input wire logic chain_output_pin_o,
	input wire logic chain_output_pin_oe,
	input wire logic pins_disconnect
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	property p_oe; pins_disconnect |-> chain_output_pin_oe; endproperty
	a_oe: assert property (p_oe) else $error("pin not driven");
	property p_par; $stable({strap_pins, chain_pins})[*6] ##0 pins_disconnect
		|-> chain_output_pin_o == ^{strap_pins[1:0], chain_pins}; endproperty
	a_par: assert property (p_par) else $error("bad parity");
	property p_in; $stable(strap_pins)[*6] ##1 (strap_pins == 3'h4 && $past(strap_pins) == 3'h0)
		##1 $stable(strap_pins)[*6] |-> pins_disconnect; endproperty
	a_in: assert property (p_in) else $error("no entry");
	// Mode must not move while the reset pin rests low
	property p_hold; (!strap_pins[2])[*8] |-> $stable(pins_disconnect); endproperty
	a_hold: assert property (p_hold) else $error("mode moved");
	property p_out; $stable(strap_pins)[*6] ##1 (strap_pins[2] && !$past(strap_pins[2])
		&& strap_pins[1:0] != 2'h0 && $stable(strap_pins[1:0]))
		##1 $stable(strap_pins)[*6] |-> !pins_disconnect; endproperty
	a_out: assert property (p_out) else $error("no exit");
	property p_func; rst_n && $past(rst_n) && !pins_disconnect
		|-> chain_output_pin_o == $past(chain_output_func)
		&& chain_output_pin_oe == $past(chain_output_func_oe); endproperty
	a_func: assert property (p_func) else $error("normal output lost");
endmodule
`default_nettype wire

// [xcbt_tester.sv]
`timescale 1ns/100ps
`default_nettype none
module xcbt_tester import xcbt_pkg::*; (
	// Board pins
	input wire logic sys_clk,
	output var xcbt_strap_t strap_pins,
	output var logic [87:0] chain_pins
);
	initial {strap_pins, chain_pins} = '0;
	// Settle covers the pin filter so each change gives one toggle
	task automatic drive(input logic [90:0] p);
		@(negedge sys_clk);
		{strap_pins, chain_pins} = p;
		repeat (8) @(negedge sys_clk);
	endtask
endmodule
`default_nettype wire

// [xcbt_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module xcbt_top_tb import xcbt_pkg::*; ;
	logic sys_clk = 1'b0, rst_n = 1'b0, o, oe, dis;
	xcbt_strap_t sp;
	logic [87:0] cp;
	logic [89:0] v;
	logic fo = 1'h1, foe = 1'h1;
	int err_count = 0, checks_done = 0;
	always #5 sys_clk = ~sys_clk;
	xcbt_tester tst_u (.sys_clk(sys_clk), .strap_pins(sp), .chain_pins(cp));
	xcbt_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .strap_pins(sp), .chain_pins(cp),
		.chain_output_func(fo), .chain_output_func_oe(foe), .chain_output_pin_o(o),
		.chain_output_pin_oe(oe), .pins_disconnect(dis));
	task automatic chk(input logic g, input logic e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("FAIL %0t got %b", $time, g);
		end
	endtask
	task automatic put(input logic r);
		tst_u.drive({r, v});
	endtask
	task automatic sc_mode(input logic [89:0] s, input logic e);
		v = s;
		put(1'b0);
		put(1'b1);
		chk(dis, e);
		chk(oe, 1'b1);
		chk(o, e ? 1'b0 : 1'b1);
	endtask
	task automatic sc_walk;
		logic e;
		e = 1'h0;
		for (int i = 89; i >= 0; i--) begin
			v[i] = 1'h1;
			e = ~e;
			put(1'h1);
			chk(o, e);
		end
		chk(o, 1'h0);
		for (int i = 0; i < 90; i++) begin
			v[i] = 1'h0;
			e = ~e;
			put(1'h1);
			chk(o, e);
		end
		chk(o, 1'h0);
	endtask
	initial begin
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		sc_mode('0, 1'b1);
		sc_walk();
		sc_mode(90'h1 << 89, 1'h0);
		v[3] = 1'h1;
		put(1'h1);
		chk(o, 1'h1);
		fo = 1'h0;
		foe = 1'h0;
		put(1'h1);
		chk(o, 1'h0);
		chk(oe, 1'h0);
		fo = 1'h1;
		foe = 1'h1;
		sc_mode('0, 1'h1);
		rst_n = 1'h0;
		@(negedge sys_clk);
		chk(dis, 1'h0);
		rst_n = 1'h1;
		put(1'h1);
		chk(dis, 1'h0);
		chk(o, 1'h1);
		summarize();
	end
	task automatic summarize;
		$display("errors %0d checks %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
endmodule
bind xcbt_top xcbt_chk #(.CHAIN_WIDTH(CHAIN_WIDTH)) chk_u (.*);
`default_nettype wire
